// file: rtl/entropy_word_source.sv
`timescale 1ns/1ns
module entropy_word_source #(
    parameter int CYCLES = rng_regs_pkg::WORD_CYCLES  // Cycles per word
) (
    input  wire logic        pclk,        // Interface clock
    input  wire logic        presetn,     // Async reset, active low
    input  wire logic        run,         // Generation enabled
    input  wire logic        entropy_in,  // Raw bit from noise source
    output logic             word_done,   // One-cycle pulse, new word
    output logic [31:0]      word         // Latest complete word
);

    localparam logic [6:0] LAST = 7'(CYCLES - 1);  // Final count

    // Synchroniser and whitening state
    logic        s1_r, s2_r, s3_r;   // Three-stage synchroniser
    logic        bit_r, bit_nxt;     // Accepted entropy bit
    logic [31:0] mix_r, mix_nxt;     // Mixing shift register
    logic [6:0]  cnt_r, cnt_nxt;     // Cycle counter
    logic [31:0] word_r, word_nxt;   // Output word
    logic        done_r, done_nxt;   // Completion pulse

    // Next values: accept bit once stages agree, mix, count
    always_comb
    begin
        bit_nxt  = (s2_r == s3_r) ? s3_r : bit_r;
        mix_nxt  = {mix_r[30:0],
                    mix_r[31] ^ mix_r[21] ^ mix_r[1] ^ mix_r[0] ^ bit_r};
        cnt_nxt  = cnt_r;
        word_nxt = word_r;
        done_nxt = 1'b0;
        if (!run)
        begin
            cnt_nxt = 7'h00;               // Restart period on enable
        end
        else if (cnt_r == LAST)
        begin
            cnt_nxt  = 7'h00;
            word_nxt = mix_nxt;            // RQ1
            done_nxt = 1'b1;               // RQ1
        end
        else
        begin
            cnt_nxt = cnt_r + 7'h01;
        end
    end

    // Registers; source clock is foreign, so it is resynchronised here
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_r   <= 1'b0;
            s2_r   <= 1'b0;
            s3_r   <= 1'b0;
            bit_r  <= 1'b0;
            mix_r  <= 32'h0000_0001;
            cnt_r  <= 7'h00;
            word_r <= rng_regs_pkg::WORD_RESET;
            done_r <= 1'b0;
        end
        else
        begin
            s1_r   <= entropy_in;          // RQ12
            s2_r   <= s1_r;                // RQ12
            s3_r   <= s2_r;
            bit_r  <= bit_nxt;
            mix_r  <= mix_nxt;
            cnt_r  <= cnt_nxt;
            word_r <= word_nxt;
            done_r <= done_nxt;
        end
    end

    assign word_done = done_r;
    assign word      = word_r;

endmodule : entropy_word_source

// file: rtl/rng_regs_pkg.sv
package rng_regs_pkg;

    // Register byte offsets
    localparam logic [7:0]  OFS_CONTROL_AND_KEY  = 8'h00;
    localparam logic [7:0]  OFS_IRQ_ENABLE_SET   = 8'h10;
    localparam logic [7:0]  OFS_IRQ_ENABLE_CLEAR = 8'h14;
    localparam logic [7:0]  OFS_IRQ_MASK_STATE   = 8'h18;
    localparam logic [7:0]  OFS_IRQ_STATUS       = 8'h1C;
    localparam logic [7:0]  OFS_RANDOM_OUTPUT    = 8'h50;

    // Field positions
    localparam int          ENABLE_BIT           = 0;
    localparam int          READY_BIT            = 0;
    localparam int          KEY_LSB              = 8;
    localparam int          KEY_MSB              = 31;

    // Write password for the control register
    localparam logic [23:0] WRITE_PASSWORD       = 24'h524E47;

    // Reset values
    localparam logic [31:0] MASK_RESET           = 32'h0000_0000;
    localparam logic [31:0] STATUS_RESET         = 32'h0000_0000;
    localparam logic [31:0] WORD_RESET           = 32'h0000_0000;

    // Interface clock cycles per random word
    localparam int          WORD_CYCLES          = 84;

    // True for any offset that holds a register
    function automatic logic is_mapped(input logic [7:0] ofs);
        is_mapped = (ofs == OFS_CONTROL_AND_KEY)  ||
                    (ofs == OFS_IRQ_ENABLE_SET)   ||
                    (ofs == OFS_IRQ_ENABLE_CLEAR) ||
                    (ofs == OFS_IRQ_MASK_STATE)   ||
                    (ofs == OFS_IRQ_STATUS)       ||
                    (ofs == OFS_RANDOM_OUTPUT);
    endfunction : is_mapped

endpackage : rng_regs_pkg

// file: rtl/true_random_word_source.sv
// Operation
// (RQ1) One 32-bit word every 84 cycles
// (RQ2) Enable only with matching key
// (RQ3) Wrong key ignores entire control write
// (RQ4) Enable-set bit one unmasks interrupt
// (RQ5) Enable-clear bit one masks interrupt
// (RQ6) Mask register shows interrupt enable, resets zero
// (RQ7) Interrupt on new word, drops on status read
// (RQ8) Ready flag zero when invalid or disabled
// (RQ9) Status read clears the ready flag
// (RQ10) Output register holds latest complete word
// (RQ11) Software checks flag before reading word
// (RQ12) Entropy source clocked independently of interface
// (RQ13) Unread word overwritten, flag stays set
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ns
module true_random_word_source #(
    parameter int CYCLES = rng_regs_pkg::WORD_CYCLES  // Cycles per word
) (
    input  wire logic        pclk,        // APB clock, 100 MHz
    input  wire logic        presetn,     // Async reset, active low
    input  wire logic        psel,        // APB select
    input  wire logic        penable,     // APB access phase
    input  wire logic        pwrite,      // APB direction, 1 = write
    input  wire logic [7:0]  paddr,       // APB byte address
    input  wire logic [31:0] pwdata,      // APB write data
    output logic [31:0]      prdata,      // APB read data
    output logic             pready,      // APB ready, always high
    output logic             pslverr,     // APB error, unmapped offset
    output logic             irq,         // Interrupt, active high
    input  wire logic        entropy_in   // Raw bit from noise source
);

    // Bus phase decode
    logic        setup;          // Setup cycle
    logic        access;         // Access cycle, completes now
    logic        wr_hit;         // Completing write
    logic        rd_hit;         // Completing read

    // Register state
    logic        gen_en_r;       // Generation enabled
    logic        gen_en_nxt;
    logic        mask_r;         // Ready interrupt unmasked
    logic        mask_nxt;
    logic        flag_r;         // Word ready flag
    logic        flag_nxt;
    logic [31:0] prdata_r;       // Read data captured in setup
    logic [31:0] prdata_nxt;
    logic        err_r;          // Error captured in setup
    logic        err_nxt;

    // Generator outputs
    logic        word_done;      // New word pulse
    logic [31:0] random_word;    // Output register contents

    // Control write decodes
    logic        ctrl_wr;        // Write to control register
    logic        key_ok;         // Password matches
    logic        status_clear;   // Status read clearing a reported flag

    assign setup   = psel && !penable;
    assign access  = psel && penable;
    assign wr_hit  = access && pwrite;
    assign rd_hit  = access && !pwrite;
    assign ctrl_wr = wr_hit && (paddr == rng_regs_pkg::OFS_CONTROL_AND_KEY);
    assign key_ok  = pwdata[rng_regs_pkg::KEY_MSB:rng_regs_pkg::KEY_LSB]
                     == rng_regs_pkg::WRITE_PASSWORD;
    // Only a flag that this read actually reported is cleared
    assign status_clear = rd_hit
                          && (paddr == rng_regs_pkg::OFS_IRQ_STATUS)
                          && prdata_r[rng_regs_pkg::READY_BIT];

    // Word generator with synchronised entropy input
    entropy_word_source #(
        .CYCLES     (CYCLES)
    ) u_source (
        .pclk       (pclk),
        .presetn    (presetn),
        .run        (gen_en_r),
        .entropy_in (entropy_in),
        .word_done  (word_done),
        .word       (random_word)
    );

    // Next state of control, mask and flag
    always_comb
    begin
        gen_en_nxt = gen_en_r;
        mask_nxt   = mask_r;
        flag_nxt   = flag_r;
        if (ctrl_wr && key_ok)
        begin
            gen_en_nxt = pwdata[rng_regs_pkg::ENABLE_BIT];  // RQ2
        end
        // Bad key leaves enable untouched   RQ3
        if (wr_hit && pwdata[0]
            && (paddr == rng_regs_pkg::OFS_IRQ_ENABLE_SET))
        begin
            mask_nxt = 1'b1;                                // RQ4
        end
        else if (wr_hit && pwdata[0]
                 && (paddr == rng_regs_pkg::OFS_IRQ_ENABLE_CLEAR))
        begin
            mask_nxt = 1'b0;                                // RQ5
        end
        if (status_clear)
        begin
            flag_nxt = 1'b0;                                // RQ9
        end
        if (word_done)
        begin
            flag_nxt = 1'b1;            // Set wins over clear  RQ13
        end
        if (!gen_en_r)
        begin
            flag_nxt = 1'b0;                                // RQ8
        end
    end

    // Control, mask and flag registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            gen_en_r <= 1'b0;
            mask_r   <= rng_regs_pkg::MASK_RESET[0];
            flag_r   <= rng_regs_pkg::STATUS_RESET[0];
        end
        else
        begin
            gen_en_r <= gen_en_nxt;
            mask_r   <= mask_nxt;
            flag_r   <= flag_nxt;
        end
    end

    // Read mux, sampled in the setup cycle
    always_comb
    begin
        prdata_nxt = prdata_r;
        err_nxt    = err_r;
        if (setup)
        begin
            err_nxt    = !rng_regs_pkg::is_mapped(paddr);
            prdata_nxt = 32'h0000_0000;
            if (!pwrite)
            begin
                case (paddr)
                    rng_regs_pkg::OFS_IRQ_MASK_STATE:
                    begin
                        prdata_nxt[0] = mask_r;             // RQ6
                    end
                    rng_regs_pkg::OFS_IRQ_STATUS:
                    begin
                        prdata_nxt[0] = flag_r;             // RQ8
                    end
                    rng_regs_pkg::OFS_RANDOM_OUTPUT:
                    begin
                        prdata_nxt = random_word;           // RQ10
                    end
                    default:
                    begin
                        prdata_nxt = 32'h0000_0000;  // Write-only or hole
                    end
                endcase
            end
        end
    end

    // Read data and error registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_r <= 32'h0000_0000;
            err_r    <= 1'b0;
        end
        else
        begin
            prdata_r <= prdata_nxt;
            err_r    <= err_nxt;
        end
    end

    // Bus answers and interrupt
    assign prdata  = prdata_r;
    assign pready  = 1'b1;
    assign pslverr = err_r && access;
    assign irq     = flag_r && mask_r;                      // RQ7

    // Helper: cycles since the previous word
    logic [7:0] gap_r;           // Cycle gap counter
    logic       seen_r;          // A word was seen while enabled

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            gap_r  <= 8'h00;
            seen_r <= 1'b0;
        end
        else if (!gen_en_r)
        begin
            gap_r  <= 8'h00;
            seen_r <= 1'b0;
        end
        else if (word_done)
        begin
            gap_r  <= 8'h01;
            seen_r <= 1'b1;
        end
        else
        begin
            gap_r  <= gap_r + 8'h01;
        end
    end

    localparam logic [7:0] GAP = 8'(CYCLES);  // Expected word spacing

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Status read that reports a ready flag
    sequence status_read_hit;
        status_clear && !word_done;
    endsequence

    // Completed word while generation stays on
    sequence word_while_on;
        word_done && gen_en_r;
    endsequence

    a_word_period: assert property (            // RQ1
        (word_done && seen_r && $past(gen_en_r)) |-> (gap_r == GAP))
        else $error("Random word spacing is wrong");

    a_key_enable: assert property (              // RQ2
        (ctrl_wr && key_ok) |=> (gen_en_r == $past(pwdata[0])))
        else $error("Keyed control write did not set enable");

    a_bad_key_ignored: assert property (         // RQ3
        (ctrl_wr && !key_ok) |=> $stable(gen_en_r))
        else $error("Control write with wrong key changed enable");

    a_mask_set: assert property (                // RQ4
        (wr_hit && pwdata[0]
         && paddr == rng_regs_pkg::OFS_IRQ_ENABLE_SET) |=> mask_r)
        else $error("Enable-set write did not unmask");

    a_mask_clear: assert property (              // RQ5
        (wr_hit && pwdata[0]
         && paddr == rng_regs_pkg::OFS_IRQ_ENABLE_CLEAR) |=> !mask_r)
        else $error("Enable-clear write did not mask");

    a_mask_readback: assert property (           // RQ6
        (setup && !pwrite && paddr == rng_regs_pkg::OFS_IRQ_MASK_STATE)
        |=> (prdata == {31'h0000_0000, $past(mask_r)}))
        else $error("Mask register read wrong value");

    // New word with the interrupt unmasked raises the line;
    // a mask write in the same cycle may legally win
    a_irq_on_word: assert property (             // RQ7
        (word_while_on and (mask_r && !wr_hit)) |=> irq)
        else $error("Interrupt missing after new word");

    a_irq_drops_read: assert property (          // RQ7
        status_read_hit |=> !irq)
        else $error("Interrupt still high after status read");

    a_flag_off_disabled: assert property (       // RQ8
        !gen_en_r |=> !flag_r [*2])
        else $error("Ready flag set while disabled");

    a_read_clears_flag: assert property (        // RQ9
        status_read_hit |=> !flag_r)
        else $error("Status read did not clear flag");

    a_word_readback: assert property (           // RQ10
        (setup && !pwrite && paddr == rng_regs_pkg::OFS_RANDOM_OUTPUT)
        |=> (prdata == $past(random_word)))
        else $error("Output register read wrong word");

    // Unread word overwritten: flag must survive the newer word
    a_overwrite_keeps: assert property (         // RQ13
        (word_while_on and (flag_r && !ctrl_wr)) |=> flag_r)
        else $error("Ready flag lost on overwrite");

    // Status read returns the flag seen in the setup cycle
    a_status_readback: assert property (         // RQ8
        (setup && !pwrite && paddr == rng_regs_pkg::OFS_IRQ_STATUS)
        |=> (prdata == {31'h0000_0000, $past(flag_r)}))
        else $error("Status register read wrong flag");

    // Word register frozen while generation is off
    a_word_held_off: assert property (           // RQ10
        !gen_en_r |=> $stable(random_word))
        else $error("Output word changed while disabled");

    // Unmapped offsets answer with an error in the access cycle
    a_slverr_hole: assert property (
        (access && !rng_regs_pkg::is_mapped(paddr)) |-> pslverr)
        else $error("Unmapped access did not report an error");

endmodule : true_random_word_source

// file: test/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    localparam int         CYC = 8;         // Short word period
    localparam logic [7:0] A_CR = 8'h00;    // Control and key
    localparam logic [7:0] A_IE = 8'h10;    // Interrupt enable set
    localparam logic [7:0] A_ID = 8'h14;    // Interrupt enable clear
    localparam logic [7:0] A_IM = 8'h18;    // Mask state
    localparam logic [7:0] A_ST = 8'h1C;    // Status
    localparam logic [7:0] A_OD = 8'h50;    // Random output
    localparam logic [23:0] PW = rng_regs_pkg::WRITE_PASSWORD; // Key
    logic        pclk;        // Bench clock
    logic        presetn;     // Reset, active low
    logic        psel;        // APB select
    logic        penable;     // APB access phase
    logic        pwrite;      // APB direction
    logic [7:0]  paddr;       // APB address
    logic [31:0] pwdata;      // APB write data
    logic [31:0] prdata;      // APB read data
    logic        pready;      // APB ready
    logic        pslverr;     // APB error
    logic        irq;         // Interrupt line
    logic        entropy_in;  // Noise bit
    int          error_cnt;   // Mismatches
    int          cmp_count;   // Comparisons
    int          cyc;         // Free cycle count
    int          t0;          // Cycle mark
    logic [31:0] rd;          // Last read data
    logic        rerr;        // Last read error
    logic [31:0] w;           // Saved word

    true_random_word_source #(.CYCLES(CYC)) i_dut (
        .pclk       (pclk),
        .presetn    (presetn),
        .psel       (psel),
        .penable    (penable),
        .pwrite     (pwrite),
        .paddr      (paddr),
        .pwdata     (pwdata),
        .prdata     (prdata),
        .pready     (pready),
        .pslverr    (pslverr),
        .irq        (irq),
        .entropy_in (entropy_in)
    );

    // Clock
    always #5 pclk = ~pclk;

    // Cycle count, noise pattern and hang guard
    always @(posedge pclk)
    begin
        cyc        <= cyc + 1;
        entropy_in <= cyc[0] ^ cyc[3] ^ cyc[6];
        if (cyc > 20000)
        begin
            error_cnt++;
            $display("mismatch at %0t: run too long", $time);
            close_out();
        end
    end

    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One APB transfer, then one idle cycle
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Wait for ready; only the run timeout ends a hang
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd      = prdata;
        rerr    = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    // Wait at clock edges for the interrupt level, bounded
    task automatic wait_irq(input logic lvl);
        int n;
        n = 0;
        while (irq !== lvl && n < 200)
        begin
            @(posedge pclk);
            n++;
        end
        check({31'h0, irq}, {31'h0, lvl});
    endtask : wait_irq

    // Reset values and an unmapped offset
    task automatic t_reset;
        check({31'h0, irq}, 32'h0);
        check({31'h0, pready}, 32'h1);
        apb(1'b0, A_IM, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, A_ST, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, A_OD, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        check({31'h0, rerr}, 32'h1);
        check(rd, 32'h0);
        $display("test reset done");
    endtask : t_reset

    // Key guard, word period, interrupt and status clear
    task automatic t_key;
        apb(1'b1, A_IE, 32'h1);
        apb(1'b1, A_CR, 32'h0000_0001);
        apb(1'b1, A_CR, {PW ^ 24'h1, 8'h01});
        repeat (3 * CYC) @(posedge pclk);
        check({31'h0, irq}, 32'h0);
        apb(1'b0, A_ST, 32'h0);
        check(rd, 32'h0);
        apb(1'b1, A_CR, {PW, 8'h01});
        wait_irq(1'b1);
        t0 = cyc;
        apb(1'b0, A_ST, 32'h0);
        check(rd, 32'h1);
        check({31'h0, irq}, 32'h0);
        apb(1'b0, A_ST, 32'h0);
        check(rd, 32'h0);
        wait_irq(1'b1);
        check(32'(cyc - t0), 32'(CYC));
        apb(1'b1, A_CR, 32'h0);
        apb(1'b0, A_ST, 32'h0);
        wait_irq(1'b1);
        $display("test key done");
    endtask : t_key

    // Mask set and clear, overrun keeps flag
    task automatic t_mask;
        apb(1'b1, A_ID, 32'h0);
        apb(1'b0, A_IM, 32'h0);
        check(rd, 32'h1);
        apb(1'b1, A_ID, 32'h1);
        apb(1'b0, A_IM, 32'h0);
        check(rd, 32'h0);
        apb(1'b1, A_IE, 32'h0);
        apb(1'b0, A_IM, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, A_ST, 32'h0);
        repeat (3 * CYC) @(posedge pclk);
        check({31'h0, irq}, 32'h0);
        apb(1'b0, A_ST, 32'h0);
        check(rd, 32'h1);
        apb(1'b0, A_OD, 32'h0);
        check({31'h0, ^rd !== 1'bx}, 32'h1);
        w = rd;
        repeat (2 * CYC) @(posedge pclk);
        apb(1'b0, A_OD, 32'h0);
        check({31'h0, rd != w}, 32'h1);
        apb(1'b1, A_IE, 32'h1);
        apb(1'b0, A_IM, 32'h0);
        check(rd, 32'h1);
        wait_irq(1'b1);
        $display("test mask done");
    endtask : t_mask

    // Disable clears the flag and freezes the word
    task automatic t_disable;
        apb(1'b1, A_CR, {PW, 8'h00});
        apb(1'b0, A_ST, 32'h0);
        apb(1'b0, A_ST, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, A_OD, 32'h0);
        w = rd;
        repeat (3 * CYC) @(posedge pclk);
        check({31'h0, irq}, 32'h0);
        apb(1'b0, A_OD, 32'h0);
        check(rd, w);
        $display("test disable done");
    endtask : t_disable

    // Counts and verdict
    task automatic close_out;
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : close_out

    // Main sequence
    initial
    begin
        pclk       = 1'b0;
        presetn    = 1'b0;
        psel       = 1'b0;
        penable    = 1'b0;
        pwrite     = 1'b0;
        paddr      = 8'h00;
        pwdata     = 32'h0;
        entropy_in = 1'b0;
        error_cnt  = 0;
        cmp_count  = 0;
        cyc        = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_key();
        t_mask();
        t_disable();
        close_out();
    end
endmodule : tb_top
